/* tb_top.sv */
// Self-checking testbench for the VC resource register bank
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cfg_vc1_enable = 1'b1;
    logic neg_pending = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] traffic_class_channel_map;
    logic [2:0] arb_scheme;
    logic vc0_enable, pat_apply, pat_loading;
    int fail_count = 0;
    int n_tests = 0;
    always #2 clk_sys = ~clk_sys;
    vcrr_regs i_vcrr_regs (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .cfg_vc1_enable, .neg_pending, .reg_rdata, .traffic_class_channel_map, .arb_scheme,
        .vc0_enable, .pat_apply, .pat_loading);
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask : rd
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : do_reset
    task automatic t_defaults(input logic [31:0] cap);
        rd(12'h154, 32'h800000FF, "ctrl"); // reset
        rd(12'h158, 32'h0, "stat"); // reset
        rd(12'h15C, cap, "cap"); // strap
        chk("map", {24'h0, traffic_class_channel_map}, 32'hFF); // map
        chk("enable", {31'h0, vc0_enable}, 32'h1); // on
        chk("scheme", {29'h0, arb_scheme}, 32'h0); // default
    endtask : t_defaults
    task automatic t_select();
        for (int c = 0; c < 8; c++) begin
            wr(12'h154, 32'h7FF0FF5A | (c << 17));
            repeat (2) @(posedge clk_sys);
            #1 chk("scheme", {29'h0, arb_scheme}, (c == 3) ? 32'h3 : 32'h0); // sel
            rd(12'h154, 32'h5A | (c << 17), "ctrl rb"); // rb
        end
        chk("enable", {31'h0, vc0_enable}, 32'h0); // off
        chk("map", {24'h0, traffic_class_channel_map}, 32'h5A); // map
    endtask : t_select
    task automatic t_table();
        int i;
        wr(12'h180, 32'h1);
        rd(12'h158, 32'h10000, "tbl set"); // set
        wr(12'h154, 32'h80010000);
        #1 chk("apply", {31'h0, pat_apply}, 32'h1); // pulse
        for (i = 0; i < 8 && pat_loading !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("apply end", {31'h0, pat_apply}, 32'h0); // one cycle
        chk("loading", {31'h0, pat_loading}, 32'h1); // load
        rd(12'h158, 32'h10000, "tbl busy"); // held
        rd(12'h154, 32'h80000000, "load rb"); // rb
        for (i = 0; i < 300 && pat_loading !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        // Both reads above spent 4 of the load cycles
        chk("load cycles", i + 4, {24'h0, vcrr_pkg::PAT_LOAD_CYCLES}); // length
        rd(12'h158, 32'h0, "tbl clr"); // clear
    endtask : t_table
    task automatic t_neg();
        @(posedge clk_sys);
        neg_pending <= 1'b1;
        rd(12'h158, 32'h20000, "neg on"); // pend
        @(posedge clk_sys);
        neg_pending <= 1'b0;
        rd(12'h158, 32'h0, "neg off"); // done
    endtask : t_neg
    task automatic t_misc();
        wr(12'h184, 32'h00550000);
        rd(12'h15C, 32'h08550019, "autoload"); // slots
        wr(12'h15C, 32'hFFFFFFFF);
        rd(12'h15C, 32'h08550019, "cap ro"); // ro
        rd(12'h1F0, 32'h0, "unmapped"); // hole
    endtask : t_misc
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        do_reset();
        t_defaults(32'h087F0019);
        t_select();
        t_table();
        t_neg();
        t_misc();
        @(posedge clk_sys);
        cfg_vc1_enable <= 1'b0;
        do_reset();
        t_defaults(32'h0);
        final_report();
    end
    // Run needs about 230 cycles
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule : tb_top

/* vcrr_pat_loader.sv */
// Port arbitration table loader sequencer
`timescale 1ns/1ps
module vcrr_pat_loader (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic load_req,
    output logic busy,
    output logic done
);
    logic [7:0] cnt_reg;

    // Walks all phases once; a request while busy restarts nothing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_reg <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (busy) begin
                if (cnt_reg == vcrr_pkg::PAT_LOAD_CYCLES - 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg + 8'h01;
            end else if (load_req) begin
                busy <= 1'b1;
                cnt_reg <= 8'h00;
            end
        end
    end
endmodule : vcrr_pat_loader

/* vcrr_pkg.sv */
// Package for the VC resource register bank: offsets, fields, reset values
package vcrr_pkg;
    localparam logic [11:0] OFF_VC0_CTRL = 12'h154;
    localparam logic [11:0] OFF_VC0_STAT = 12'h158;
    localparam logic [11:0] OFF_VC1_CAP = 12'h15C;
    // Extra registers for the datapath handshakes
    localparam logic [11:0] OFF_PAT_WRITE = 12'h180;
    localparam logic [11:0] OFF_AUTOLOAD = 12'h184;

    localparam int TC_MAP_LSB = 0;
    localparam int PAT_LOAD_BIT = 16;
    localparam int ARB_SEL_LSB = 17;
    localparam int CHAN_ID_LSB = 24;
    localparam int VC_EN_BIT = 31;
    localparam int PAT_STAT_BIT = 16;
    localparam int NEG_PEND_BIT = 17;
    localparam int APS_ONLY_BIT = 14;
    localparam int REJ_SNOOP_BIT = 15;
    localparam int SLOTS_LSB = 16;
    localparam int TBL_OFF_LSB = 24;

    localparam logic [7:0] TC_MAP_RST = 8'hFF;
    localparam logic [2:0] ARB_SEL_RST = 3'h0;
    localparam logic [2:0] ARB_SEL_WRR = 3'h3;
    localparam logic [2:0] CHAN_ID_VC0 = 3'h0;
    localparam logic VC_EN_RST = 1'b1;
    localparam logic [7:0] CAP1_ARB_ON = 8'h19;
    localparam logic [7:0] CAP1_ARB_OFF = 8'h00;
    localparam logic [6:0] CAP1_SLOTS_ON = 7'h7F;
    localparam logic [6:0] CAP1_SLOTS_OFF = 7'h00;
    localparam logic [7:0] CAP1_TOFF_ON = 8'h08;
    localparam logic [7:0] CAP1_TOFF_OFF = 8'h00;
    localparam int ARB_PHASES = 128;
    // Cycles the table loader needs after a load request
    localparam logic [7:0] PAT_LOAD_CYCLES = 8'h80;
endpackage : vcrr_pkg

/* vcrr_regs.sv */
// VC0 control/status and VC1 capability registers
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module vcrr_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic cfg_vc1_enable,
    input wire logic neg_pending,
    output logic [31:0] reg_rdata,
    output logic [7:0] traffic_class_channel_map,
    output logic [2:0] arb_scheme,
    output logic vc0_enable,
    output logic pat_apply,
    output logic pat_loading
);
    logic [7:0] tc_map_reg;
    logic [2:0] arb_sel_reg;
    logic vc_en_reg;
    logic pat_stat_reg;
    logic neg_pend_reg;
    logic [7:0] cap_arb_reg;
    logic [6:0] cap_slots_reg;
    logic [7:0] cap_toff_reg;
    logic rst_d_reg;
    logic ld_busy;
    logic ld_done;
    logic wr_ctrl;
    logic wr_auto;
    logic [31:0] rdata_next;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_ctrl = reg_wr && hit(reg_addr, vcrr_pkg::OFF_VC0_CTRL);
    assign wr_auto = reg_wr && hit(reg_addr, vcrr_pkg::OFF_AUTOLOAD);

    // Map, written by software through the control register only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tc_map_reg <= vcrr_pkg::TC_MAP_RST;
        end else if (wr_ctrl) begin
            tc_map_reg <= reg_wdata[vcrr_pkg::TC_MAP_LSB +: 8];
        end
    end

    // Stored as written; mapped at use
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            arb_sel_reg <= vcrr_pkg::ARB_SEL_RST;
        end else if (wr_ctrl) begin
            arb_sel_reg <= reg_wdata[vcrr_pkg::ARB_SEL_LSB +: 3];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            vc_en_reg <= vcrr_pkg::VC_EN_RST;
        end else if (wr_ctrl) begin
            vc_en_reg <= reg_wdata[vcrr_pkg::VC_EN_BIT];
        end
    end

    // Load pulse, one cycle; bit itself is not stored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pat_apply <= 1'b0;
        end else begin
            pat_apply <= wr_ctrl && reg_wdata[vcrr_pkg::PAT_LOAD_BIT];
        end
    end

    vcrr_pat_loader i_vcrr_pat_loader (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load_req(pat_apply),
        .busy(ld_busy),
        .done(ld_done)
    );

    // Table write sets; set wins over loader clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pat_stat_reg <= 1'b0;
        end else if (reg_wr && hit(reg_addr, vcrr_pkg::OFF_PAT_WRITE)) begin
            pat_stat_reg <= 1'b1;
        end else if (ld_done) begin
            pat_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            neg_pend_reg <= 1'b0;
        end else begin
            neg_pend_reg <= neg_pending;
        end
    end

    // Strap sampled after reset release, never by the reset itself
    always_ff @(posedge clk_sys) begin
        rst_d_reg <= sys_rst;
    end

    // Strap-dependent VC1 defaults, autoload may override slots
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cap_arb_reg <= vcrr_pkg::CAP1_ARB_OFF;
            cap_slots_reg <= vcrr_pkg::CAP1_SLOTS_OFF;
            cap_toff_reg <= vcrr_pkg::CAP1_TOFF_OFF;
        end else if (rst_d_reg) begin
            cap_arb_reg <= cfg_vc1_enable ? vcrr_pkg::CAP1_ARB_ON : vcrr_pkg::CAP1_ARB_OFF;
            cap_slots_reg <= cfg_vc1_enable ? vcrr_pkg::CAP1_SLOTS_ON
                                            : vcrr_pkg::CAP1_SLOTS_OFF;
            cap_toff_reg <= cfg_vc1_enable ? vcrr_pkg::CAP1_TOFF_ON : vcrr_pkg::CAP1_TOFF_OFF;
        end else if (wr_auto) begin
            cap_slots_reg <= reg_wdata[vcrr_pkg::SLOTS_LSB +: 7];
        end
    end

    // Read mux, constant and reserved bits zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (reg_addr)
            vcrr_pkg::OFF_VC0_CTRL: begin
                rdata_next[vcrr_pkg::TC_MAP_LSB +: 8] = tc_map_reg;
                rdata_next[vcrr_pkg::ARB_SEL_LSB +: 3] = arb_sel_reg;
                rdata_next[vcrr_pkg::CHAN_ID_LSB +: 3] = vcrr_pkg::CHAN_ID_VC0;
                rdata_next[vcrr_pkg::VC_EN_BIT] = vc_en_reg;
            end
            vcrr_pkg::OFF_VC0_STAT: begin
                rdata_next[vcrr_pkg::PAT_STAT_BIT] = pat_stat_reg;
                rdata_next[vcrr_pkg::NEG_PEND_BIT] = neg_pend_reg;
            end
            // Capability bits advertise RR, WRR128, TWRR128 on VC1 when cfg_vc1_enable was set at reset release, else zero
            vcrr_pkg::OFF_VC1_CAP: begin
                rdata_next[7:0] = cap_arb_reg;
                rdata_next[vcrr_pkg::APS_ONLY_BIT] = 1'b0;
                rdata_next[vcrr_pkg::REJ_SNOOP_BIT] = 1'b0;
                rdata_next[vcrr_pkg::SLOTS_LSB +: 7] = cap_slots_reg;
                rdata_next[vcrr_pkg::TBL_OFF_LSB +: 8] = cap_toff_reg;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Codes other than WRR (3) fall back to default scheme
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            arb_scheme <= vcrr_pkg::ARB_SEL_RST;
        end else if (arb_sel_reg == vcrr_pkg::ARB_SEL_WRR) begin
            arb_scheme <= vcrr_pkg::ARB_SEL_WRR;
        end else begin
            arb_scheme <= vcrr_pkg::ARB_SEL_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            traffic_class_channel_map <= vcrr_pkg::TC_MAP_RST;
            vc0_enable <= vcrr_pkg::VC_EN_RST;
            pat_loading <= 1'b0;
        end else begin
            traffic_class_channel_map <= tc_map_reg;
            vc0_enable <= vc_en_reg;
            pat_loading <= ld_busy;
        end
    end
endmodule : vcrr_regs

/* vcrr_regs_props.sv */
// Assertion checker for the VC resource register bank
`timescale 1ns/1ps
module vcrr_regs_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic cfg_vc1_enable,
    input wire logic neg_pending,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] traffic_class_channel_map,
    input wire logic [2:0] arb_scheme,
    input wire logic vc0_enable,
    input wire logic pat_apply,
    input wire logic pat_loading
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [8:0] run_cnt;
    // Counter, since a 128-long repetition is too costly
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !pat_loading) run_cnt <= 9'h0;
        else run_cnt <= run_cnt + 9'h1;
    end
    a_reset_defaults: assert property ($fell(sys_rst) |->
        traffic_class_channel_map == 8'hFF && vc0_enable && !pat_loading && arb_scheme == 3'h0)
        else $error("bad defaults");
    a_ctrl_fixed_zero: assert property ($past(reg_rd && reg_addr == 12'h154)
        |-> reg_rdata[30:20] == 11'h0 && reg_rdata[16:8] == 9'h0) else $error("ctrl zero bits set");
    a_apply_on_load: assert property (reg_wr && reg_addr == 12'h154 && reg_wdata[16]
        |=> pat_apply) else $error("no apply pulse");
    a_apply_cause: assert property (pat_apply |->
        $past(reg_wr && reg_addr == 12'h154 && reg_wdata[16])) else $error("stray apply");
    a_scheme_legal: assert property (arb_scheme == 3'h0 || arb_scheme == 3'h3)
        else $error("illegal scheme");
    a_scheme_follow: assert property (reg_wr && reg_addr == 12'h154
        && reg_wdata[19:17] == 3'h3 |-> ##[1:2] arb_scheme == 3'h3) else $error("scheme not taken");
    a_map_follow: assert property (reg_wr && reg_addr == 12'h154 |=> ##1
        traffic_class_channel_map == $past(reg_wdata[7:0], 2)) else $error("map not taken");
    a_load_starts: assert property (pat_apply |-> ##[1:4] pat_loading)
        else $error("loader idle");
    a_load_bounded: assert property (run_cnt <= 9'h80) else $error("loader too long");
    c_apply: cover property (pat_apply);
    c_load_done: cover property ($fell(pat_loading));
    c_wrr: cover property (arb_scheme == 3'h3);
endmodule : vcrr_regs_props

bind vcrr_regs vcrr_regs_props i_vcrr_regs_props (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .cfg_vc1_enable, .neg_pending, .reg_rdata, .traffic_class_channel_map,
    .arb_scheme, .vc0_enable, .pat_apply, .pat_loading);
